// >>> logic/dblg_pkg.sv
// Functional notes
// - Gate phase codes pick clk90/180/270/0
// - Four two-bit phase fields, reset 0x1
// - Training, drift update, software write load phases
// - Global disable blocks drift phase updates
// - Latency codes 0..5 add cycles, 6/7 reserved
// - Training loads latency, software write overrides
// - Four three-bit latency fields, reset zero
// - Lead bit: termination two or one cycles early
// - Termination held 0..3 cycles after postamble
// - Data termination dynamic or constant per bit
// - Strobe termination dynamic or constant per bit
// - Write strobe drive select, reset 0x1
// - Complement strobe inverse; tristate when disabled
// - Strobe receiver powerdown ORed with common bit
package dblg_pkg;
  localparam logic [11:0] DBLG_GCR_OFS = 12'h280;
  localparam logic [11:0] DBLG_STR_OFS = 12'h254;
  localparam logic [11:0] DBLG_AUX_OFS = 12'h2A0;
  localparam int DBLG_RANKS = 4;
  localparam int DBLG_PHASE_LSB = 12;
  localparam int DBLG_LAT_LSB = 0;
  localparam logic [1:0] DBLG_PHASE_RST = 2'h1;
  localparam logic [2:0] DBLG_LAT_RST = 3'h0;
  localparam logic [2:0] DBLG_LAT_MAX = 3'h5;
  localparam int DBLG_LEAD_BIT = 13;
  localparam int DBLG_HOLD_LSB = 11;
  localparam int DBLG_DATA_DYNAMIC_TERM_EN_BIT = 10;
  localparam int DBLG_STROBE_DYNAMIC_TERM_EN_BIT = 9;
  localparam int DBLG_WSEL_LSB = 7;
  localparam int DBLG_RXPD_BIT = 6;
  localparam int DBLG_DATA_TERM_ENABLE_BIT = 2;
  localparam int DBLG_STROBE_TERM_ENABLE_BIT = 1;
  localparam logic [1:0] DBLG_WSEL_RST = 2'h1;
  localparam logic [4:0] DBLG_NOM_RL = 5'h5;
  localparam int DBLG_LEAD_FAR = 2;
  localparam int DBLG_LEAD_NEAR = 1;

  typedef struct packed {
    logic [1:0] phase_sel;
    logic [2:0] extra_lat;
  } dblg_rank_t;

  typedef struct packed {
    logic lead_sel;
    logic [1:0] hold_cyc;
    logic dq_dyn;
    logic dqs_dyn;
    logic [1:0] wsel;
    logic rx_pd;
    logic dq_odt;
    logic dqs_odt;
  } dblg_gcr_t;
endpackage

// >>> logic/dblg_term.sv
`timescale 1ns/10ps
module dblg_term (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic read_start,
  input wire logic read_end,
  input wire logic lead_sel,
  input wire logic [1:0] hold_cyc,
  output logic rd_term
);
  import dblg_pkg::*;
  // ==========================================================
  // Read termination window
  typedef struct packed {
    logic [1:0] lead;
    logic active;
    logic [2:0] hold;
    logic out;
  } dblg_term_st_t;
  dblg_term_st_t st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    if (st_reg.lead != 2'h0) begin
      st_next.lead = st_reg.lead - 2'h1;
      if (st_reg.lead == 2'h1) begin
        st_next.active = 1'b1;
      end
    end
    if (read_start) begin
      // Lead count chosen so term leads the preamble
      st_next.lead = lead_sel ? 2'(DBLG_LEAD_NEAR) : 2'(DBLG_LEAD_FAR);
      st_next.hold = 3'h0;
    end
    if (read_end && st_reg.active) begin
      st_next.hold = {1'b0, hold_cyc} + 3'h1;
    end
    if (st_reg.hold != 3'h0 && !read_end) begin
      st_next.hold = st_reg.hold - 3'h1;
      if (st_reg.hold == 3'h1) begin
        st_next.active = 1'b0;
      end
    end
    st_next.out = st_next.active;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign rd_term = st_reg.out;

  term_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
    (read_end && st_reg.active && hold_cyc == 2'h0 && !read_start) |=> ##1 !rd_term)
    else $error("termination not dropped after postamble");
  term_lead_a: assert property (@(posedge pclk) disable iff (!presetn)
    (read_start && lead_sel && !st_reg.active) |=> ##1 rd_term)
    else $error("near lead termination late");
endmodule

// >>> logic/dblg_ctrl.sv
`timescale 1ns/10ps
module dblg_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic train_we,
  input wire logic [1:0] train_rank,
  input wire logic [1:0] train_phase,
  input wire logic [2:0] train_lat,
  input wire logic drift_we,
  input wire logic [1:0] drift_rank,
  input wire logic [1:0] drift_phase,
  input wire logic drift_upd_dis,
  input wire logic common_rx_powerdown,
  input wire logic read_cmd,
  input wire logic [1:0] read_rank,
  input wire logic read_done,
  input wire logic clk90_ph,
  input wire logic clk180_ph,
  input wire logic clk270_ph,
  input wire logic clk0_ph,
  input wire logic wr_clk_ph,
  input wire logic strobe_oe,
  output logic data_term,
  output logic strobe_term,
  output logic wr_strobe_o,
  output logic wr_strobe_n_o,
  output logic wr_strobe_oe_n,
  output logic read_strobe_rx_powerdown,
  output logic gate_en
);
  import dblg_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    dblg_rank_t [DBLG_RANKS-1:0] rank;
    dblg_gcr_t gcr;
    logic [4:0] gate_cnt;
    logic [1:0] gate_rank;
    logic gate_arm;
    logic gate_win;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic dterm;
    logic sterm;
    logic ws;
    logic wsn;
    logic wsoe_n;
    logic rxpd;
    logic gate;
  } dblg_st_t;
  dblg_st_t st_reg, st_next;
  logic rd_term;

  function automatic logic [31:0] str_word(input dblg_rank_t [DBLG_RANKS-1:0] r);
    logic [31:0] w;
    w = '0;
    for (int i = 0; i < DBLG_RANKS; i++) begin
      w[DBLG_PHASE_LSB+2*i +: 2] = r[i].phase_sel;
      w[DBLG_LAT_LSB+3*i +: 3] = r[i].extra_lat;
    end
    return w;
  endfunction

  function automatic logic [31:0] gcr_word(input dblg_gcr_t g);
    logic [31:0] w;
    w = '0;
    w[DBLG_LEAD_BIT] = g.lead_sel;
    w[DBLG_HOLD_LSB +: 2] = g.hold_cyc;
    w[DBLG_DATA_DYNAMIC_TERM_EN_BIT] = g.dq_dyn;
    w[DBLG_STROBE_DYNAMIC_TERM_EN_BIT] = g.dqs_dyn;
    w[DBLG_WSEL_LSB +: 2] = g.wsel;
    w[DBLG_RXPD_BIT] = g.rx_pd;
    w[DBLG_DATA_TERM_ENABLE_BIT] = g.dq_odt;
    w[DBLG_STROBE_TERM_ENABLE_BIT] = g.dqs_odt;
    return w;
  endfunction

  // Reserved latency codes saturate to the top legal value
  function automatic logic [2:0] clamp_lat(input logic [2:0] v);
    return (v > DBLG_LAT_MAX) ? DBLG_LAT_MAX : v;
  endfunction

  function automatic logic phase_clk(input logic [1:0] s, input logic c90,
                                     input logic c180, input logic c270, input logic c0);
    logic r;
    r = c0;
    case (s)
      2'h0: r = c90;
      2'h1: r = c180;
      2'h2: r = c270;
      default: r = c0;
    endcase
    return r;
  endfunction

  dblg_term u_term (
    .pclk(pclk),
    .presetn(presetn),
    .read_start(read_cmd),
    .read_end(read_done),
    .lead_sel(st_reg.gcr.lead_sel),
    .hold_cyc(st_reg.gcr.hold_cyc),
    .rd_term(rd_term)
  );

  // ==========================================================
  // Next state
  always_comb begin
    logic setup;
    logic acc;
    logic [1:0] sel_ph;
    logic sel_clk;
    setup = 1'b0;
    acc = 1'b0;
    sel_ph = 2'h0;
    sel_clk = 1'b0;
    st_next = st_reg;
    setup = psel && !penable;
    acc = psel && penable && st_reg.ready;
    st_next.ready = setup;
    // Training first, then drift, software last so it wins
    if (train_we) begin
      st_next.rank[train_rank].phase_sel = train_phase;
      st_next.rank[train_rank].extra_lat = clamp_lat(train_lat);
    end
    if (drift_we && !drift_upd_dis) begin
      st_next.rank[drift_rank].phase_sel = drift_phase;
    end
    if (acc && pwrite && !st_reg.err) begin
      if (paddr == DBLG_STR_OFS) begin
        for (int i = 0; i < DBLG_RANKS; i++) begin
          st_next.rank[i].phase_sel = pwdata[DBLG_PHASE_LSB+2*i +: 2];
          st_next.rank[i].extra_lat = clamp_lat(pwdata[DBLG_LAT_LSB+3*i +: 3]);
        end
      end else if (paddr == DBLG_GCR_OFS) begin
        st_next.gcr.lead_sel = pwdata[DBLG_LEAD_BIT];
        st_next.gcr.hold_cyc = pwdata[DBLG_HOLD_LSB +: 2];
        st_next.gcr.dq_dyn = pwdata[DBLG_DATA_DYNAMIC_TERM_EN_BIT];
        st_next.gcr.dqs_dyn = pwdata[DBLG_STROBE_DYNAMIC_TERM_EN_BIT];
        st_next.gcr.wsel = pwdata[DBLG_WSEL_LSB +: 2];
        st_next.gcr.rx_pd = pwdata[DBLG_RXPD_BIT];
        st_next.gcr.dq_odt = pwdata[DBLG_DATA_TERM_ENABLE_BIT];
        st_next.gcr.dqs_odt = pwdata[DBLG_STROBE_TERM_ENABLE_BIT];
      end
    end
    if (setup) begin
      st_next.err = 1'b0;
      st_next.rdata = '0;
      if (paddr == DBLG_STR_OFS) begin
        st_next.rdata = str_word(st_reg.rank);
      end else if (paddr == DBLG_GCR_OFS) begin
        st_next.rdata = gcr_word(st_reg.gcr);
      end else if (paddr == DBLG_AUX_OFS) begin
        st_next.rdata = {24'h0, st_reg.gate_win, st_reg.gate_arm, st_reg.gate_rank,
                         st_reg.gate_cnt[3:0]};
      end else begin
        st_next.err = 1'b1;
      end
    end
    // Gate window: nominal latency plus rank extra, then phase clock
    if (read_cmd) begin
      st_next.gate_arm = 1'b1;
      st_next.gate_rank = read_rank;
      st_next.gate_cnt = DBLG_NOM_RL + {2'h0, st_reg.rank[read_rank].extra_lat};
    end else if (st_reg.gate_arm) begin
      if (st_reg.gate_cnt == 5'h0) begin
        st_next.gate_arm = 1'b0;
        st_next.gate_win = 1'b1;
      end else begin
        st_next.gate_cnt = st_reg.gate_cnt - 5'h1;
      end
    end
    if (read_done) begin
      st_next.gate_win = 1'b0;
    end
    sel_ph = st_reg.rank[st_reg.gate_rank].phase_sel;
    sel_clk = phase_clk(sel_ph, clk90_ph, clk180_ph, clk270_ph, clk0_ph);
    st_next.gate = st_reg.gate_win && sel_clk;
    st_next.dterm = st_reg.gcr.dq_dyn ? (rd_term && st_reg.gcr.dq_odt)
                                      : st_reg.gcr.dq_odt;
    st_next.sterm = st_reg.gcr.dqs_dyn ? (rd_term && st_reg.gcr.dqs_odt)
                                       : st_reg.gcr.dqs_odt;
    case (st_reg.gcr.wsel)
      2'h0: st_next.ws = 1'b0;
      2'h1: st_next.ws = !wr_clk_ph;
      2'h2: st_next.ws = wr_clk_ph;
      default: st_next.ws = 1'b1;
    endcase
    st_next.wsn = !st_next.ws;
    st_next.wsoe_n = !strobe_oe;
    st_next.rxpd = st_reg.gcr.rx_pd || common_rx_powerdown;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
      for (int i = 0; i < DBLG_RANKS; i++) begin
        st_reg.rank[i].phase_sel <= DBLG_PHASE_RST;
        st_reg.rank[i].extra_lat <= DBLG_LAT_RST;
      end
      st_reg.gcr.dq_dyn <= 1'b1;
      st_reg.gcr.dqs_dyn <= 1'b1;
      st_reg.gcr.wsel <= DBLG_WSEL_RST;
      st_reg.wsoe_n <= 1'b1;
      // Complement starts high so the pair is inverse from the first edge
      st_reg.wsn <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata = st_reg.rdata;
  assign pready = st_reg.ready;
  assign pslverr = st_reg.ready && st_reg.err;
  assign data_term = st_reg.dterm;
  assign strobe_term = st_reg.sterm;
  assign wr_strobe_o = st_reg.ws;
  assign wr_strobe_n_o = st_reg.wsn;
  assign wr_strobe_oe_n = st_reg.wsoe_n;
  assign read_strobe_rx_powerdown = st_reg.rxpd;
  assign gate_en = st_reg.gate;

  // ==========================================================
  // Checks
  strobe_compl_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_strobe_n_o == !wr_strobe_o)
    else $error("complement strobe mismatch");
  strobe_oe_a: assert property (@(posedge pclk) disable iff (!presetn)
    !strobe_oe |=> wr_strobe_oe_n)
    else $error("strobe not released");
  rx_pd_a: assert property (@(posedge pclk) disable iff (!presetn)
    common_rx_powerdown |=> read_strobe_rx_powerdown)
    else $error("common powerdown ignored");
  lat_legal_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg.rank[0].extra_lat <= DBLG_LAT_MAX && st_reg.rank[2].extra_lat <= DBLG_LAT_MAX)
    else $error("reserved latency stored");
  drift_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    (drift_upd_dis && !train_we && !(psel && penable && pwrite))
      |=> $stable(st_reg.rank[0].phase_sel))
    else $error("phase changed while drift disabled");
  dq_static_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!st_reg.gcr.dq_dyn && $stable(st_reg.gcr)) |=> data_term == $past(st_reg.gcr.dq_odt))
    else $error("static data termination wrong");
  dqs_dyn_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_reg.gcr.dqs_dyn && !rd_term) |=> !strobe_term)
    else $error("strobe termination outside read");
  gate_open_a: assert property (@(posedge pclk) disable iff (!presetn)
    (read_cmd && st_reg.rank[read_rank].extra_lat == 3'h0) ##1 (!read_cmd && !read_done) [*6]
      |=> st_reg.gate_win)
    else $error("gate window late");
  sw_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pready && pwrite && !pslverr && paddr == DBLG_STR_OFS)
      |=> st_reg.rank[0].phase_sel == $past(pwdata[13:12]))
    else $error("software phase write lost");
  phase_rst_a: assert property (@(posedge pclk) $rose(presetn) |-> st_reg.rank[2].phase_sel == DBLG_PHASE_RST)
    else $error("phase reset value wrong");
endmodule

// >>> verif/dblg_ddr_model.sv
`timescale 1ns/10ps
// ==========================================
// Far side: memory returns one read burst
module dblg_ddr_model #(
  parameter int GAP = 14
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic read_cmd,
  output logic read_done
);
  int cnt;
  // Fixed burst length; the memory never ends a burst early
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      read_done <= 1'b0;
    end else begin
      read_done <= (cnt == 1);
      cnt <= read_cmd ? GAP : (cnt > 0 ? cnt - 1 : 0);
    end
  end
endmodule

// >>> verif/test_ddr_byte_lane_gating_odt_ctrl.sv
`timescale 1ns/10ps
// ==========================================
// Bench for the byte lane control block
module test_ddr_byte_lane_gating_odt_ctrl;
  import dblg_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, p1, p2, pick;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic train_we, drift_we, drift_upd_dis, common_rx_powerdown, read_cmd, read_done;
  logic [1:0] train_rank, train_phase, drift_rank, drift_phase, read_rank;
  logic [2:0] train_lat;
  logic clk90_ph, clk180_ph, clk270_ph, clk0_ph, wr_clk_ph, strobe_oe;
  logic data_term, strobe_term, wr_strobe_o, wr_strobe_n_o, wr_strobe_oe_n;
  logic read_strobe_rx_powerdown, gate_en;
  int failures, checks_done, cyc, u0, d0, u1, d1;
  wire logic probe = pick ? data_term : gate_en;

  dblg_ctrl dblg_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .train_we, .train_rank, .train_phase, .train_lat,
    .drift_we, .drift_rank, .drift_phase, .drift_upd_dis, .common_rx_powerdown,
    .read_cmd, .read_rank, .read_done, .clk90_ph, .clk180_ph, .clk270_ph, .clk0_ph,
    .wr_clk_ph, .strobe_oe, .data_term, .strobe_term, .wr_strobe_o, .wr_strobe_n_o,
    .wr_strobe_oe_n, .read_strobe_rx_powerdown, .gate_en);
  dblg_ddr_model dblg_ddr_model_i (.pclk(pclk), .presetn(presetn), .read_cmd(read_cmd),
    .read_done(read_done));

  // ==========================================
  // Clock, stimulus source, timeout
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) wr_clk_ph <= ~wr_clk_ph;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      failures++;
      wrap_up();
    end
  end

  // ==========================================
  // Compare and bus tasks
  task note(input logic ok);
    checks_done++;
    if (!ok) begin
      failures++;
      $display("MISMATCH t=%0t unexpected result", $time);
    end
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    note(got === exp);
  endtask
  task chk_b(input logic got, input logic exp);
    note(got === exp);
  endtask
  task chk_n(input int got, input int exp);
    note(got == exp);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Request held until ready is seen at a rising edge; no cycle count assumed
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rchk(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask
  function logic [31:0] gcr(input logic l, input logic [1:0] h, input logic dd, input logic sd,
    input logic [1:0] w, input logic pd, input logic o, input logic so);
    gcr = {18'h0, l, h, dd, sd, w, pd, 3'h0, o, so, 1'b0};
  endfunction
  task settle;
    repeat (2) @(negedge pclk);
  endtask
  // Edges from a read until the probed signal rises and falls; 99 means never
  task rd(output int up, output int dn);
    int n;
    begin
      @(posedge pclk);
      read_cmd <= 1'b1;
      read_rank <= 2'h0;
      @(posedge pclk);
      read_cmd <= 1'b0;
      up = 99;
      dn = 99;
      for (n = 1; n < 45; n++) begin
        @(negedge pclk);
        if (up == 99 && probe === 1'b1) up = n;
        if (up != 99 && dn == 99 && probe === 1'b0) dn = n;
      end
    end
  endtask
  task drift(input logic dis);
    @(posedge pclk);
    drift_upd_dis <= dis;
    drift_we <= 1'b1;
    drift_rank <= 2'h0;
    drift_phase <= 2'h2;
    @(posedge pclk);
    drift_we <= 1'b0;
  endtask
  task ws_phase(input logic [1:0] w, output logic p);
    apb(1'b1, DBLG_GCR_OFS, gcr(1'b0, 2'h0, 1'b1, 1'b1, w, 1'b0, 1'b0, 1'b0));
    settle();
    p = wr_strobe_o ^ wr_clk_ph;
    @(negedge pclk);
    chk_b(wr_strobe_o ^ wr_clk_ph, p);
    chk_b(wr_strobe_n_o, ~wr_strobe_o);
  endtask

  // ==========================================
  // Scenarios
  task t_reset_train;
    rchk(DBLG_STR_OFS, 32'h00055000);
    rchk(DBLG_GCR_OFS, 32'h00000680);
    @(posedge pclk);
    train_we <= 1'b1;
    train_rank <= 2'h2;
    train_phase <= 2'h3;
    train_lat <= 3'h4;
    @(posedge pclk);
    train_we <= 1'b0;
    rchk(DBLG_STR_OFS, 32'h00075100);
    apb(1'b1, DBLG_STR_OFS, 32'h00055000);
    rchk(DBLG_STR_OFS, 32'h00055000);
    drift(1'b1);
    rchk(DBLG_STR_OFS, 32'h00055000);
    drift(1'b0);
    rchk(DBLG_STR_OFS, 32'h00056000);
  endtask
  task t_regs;
    apb(1'b1, DBLG_STR_OFS, 32'h00055006);
    rchk(DBLG_STR_OFS, 32'h00055005);
    apb(1'b1, DBLG_STR_OFS, 32'hFFFFFFFF);
    rchk(DBLG_STR_OFS, 32'h000FFB6D);
    apb(1'b1, DBLG_GCR_OFS, 32'hFFFFFFFF);
    rchk(DBLG_GCR_OFS, 32'h00003FC6);
    rchk(12'h300, 32'h0);
    chk_b(e, 1'b1);
    apb(1'b1, DBLG_GCR_OFS, gcr(1'b0, 2'h0, 1'b1, 1'b1, 2'h2, 1'b0, 1'b0, 1'b0));
    settle();
    chk_b(read_strobe_rx_powerdown, 1'b0);
    @(posedge pclk);
    common_rx_powerdown <= 1'b1;
    settle();
    chk_b(read_strobe_rx_powerdown, 1'b1);
    @(posedge pclk);
    common_rx_powerdown <= 1'b0;
    settle();
    chk_b(read_strobe_rx_powerdown, 1'b0);
    apb(1'b1, DBLG_GCR_OFS, gcr(1'b0, 2'h0, 1'b1, 1'b1, 2'h2, 1'b1, 1'b0, 1'b0));
    settle();
    chk_b(read_strobe_rx_powerdown, 1'b1);
  endtask
  task t_strobe;
    chk_b(wr_strobe_oe_n, 1'b1);
    @(posedge pclk);
    strobe_oe <= 1'b1;
    apb(1'b1, DBLG_GCR_OFS, gcr(1'b0, 2'h0, 1'b1, 1'b1, 2'h0, 1'b0, 1'b0, 1'b0));
    settle();
    chk(32'({wr_strobe_oe_n, wr_strobe_o, wr_strobe_n_o}), 32'h1);
    apb(1'b1, DBLG_GCR_OFS, gcr(1'b0, 2'h0, 1'b1, 1'b1, 2'h3, 1'b0, 1'b0, 1'b0));
    settle();
    chk(32'({wr_strobe_oe_n, wr_strobe_o, wr_strobe_n_o}), 32'h2);
    ws_phase(2'h2, p1);
    ws_phase(2'h1, p2);
    chk_b(p1 ^ p2, 1'b1);
    @(posedge pclk);
    strobe_oe <= 1'b0;
    settle();
    chk_b(wr_strobe_oe_n, 1'b1);
  endtask
  task t_term;
    apb(1'b1, DBLG_GCR_OFS, gcr(1'b0, 2'h0, 1'b1, 1'b1, 2'h2, 1'b0, 1'b1, 1'b1));
    settle();
    chk(32'({data_term, strobe_term}), 32'h0);
    pick = 1'b1;
    rd(u0, d0);
    apb(1'b1, DBLG_GCR_OFS, gcr(1'b1, 2'h3, 1'b1, 1'b1, 2'h2, 1'b0, 1'b1, 1'b1));
    rd(u1, d1);
    chk_n(u0, u1 + 1);
    chk_n(d1, d0 + 3);
    apb(1'b1, DBLG_GCR_OFS, gcr(1'b0, 2'h0, 1'b0, 1'b0, 2'h2, 1'b0, 1'b1, 1'b0));
    settle();
    chk(32'({data_term, strobe_term}), 32'h2);
    apb(1'b1, DBLG_GCR_OFS, gcr(1'b0, 2'h0, 1'b0, 1'b0, 2'h2, 1'b0, 1'b0, 1'b1));
    settle();
    chk(32'({data_term, strobe_term}), 32'h1);
  endtask
  task t_gate;
    pick = 1'b0;
    @(posedge pclk);
    clk180_ph <= 1'b1;
    apb(1'b1, DBLG_STR_OFS, 32'h00055000);
    rd(u0, d0);
    apb(1'b1, DBLG_STR_OFS, 32'h00055003);
    rd(u1, d1);
    chk_n(u1, u0 + 3);
    for (int k = 0; k < 4; k++) begin
      @(posedge pclk);
      {clk0_ph, clk270_ph, clk180_ph, clk90_ph} <= 4'h1 << k;
      apb(1'b1, DBLG_STR_OFS, 32'h00054000 | (32'(k) << 12));
      rd(u1, d1);
      chk_n(u1, u0);
    end
    @(posedge pclk);
    {clk0_ph, clk270_ph, clk180_ph, clk90_ph} <= 4'h2;
    apb(1'b1, DBLG_STR_OFS, 32'h00054000);
    rd(u1, d1);
    chk_n(u1, 99);
    // Window closed and counter spent once the burst has ended
    rchk(DBLG_AUX_OFS, 32'h0);
  endtask

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, train_we, drift_we} = '0;
    {drift_upd_dis, common_rx_powerdown, read_cmd, train_rank, train_phase} = '0;
    {train_lat, drift_rank, drift_phase, read_rank, strobe_oe, pick} = '0;
    {clk90_ph, clk180_ph, clk270_ph, clk0_ph, wr_clk_ph} = '0;
    failures = 0;
    checks_done = 0;
    cyc = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_train();
    t_regs();
    t_strobe();
    t_term();
    t_gate();
    wrap_up();
  end
endmodule
